// >>> core/mrag_defs.svh
// Constants for the memory reference address generator.
// Contract
// RULE1 - Short format sign-extends its 16-bit displacement to 32 bits.
// RULE2 - Long format uses its full 32-bit displacement unmodified.
// RULE3 - Decode indexed and long flags; space bits 00/11 code, 01/10 data.
// RULE4 - Direct data reference address is the displacement alone.
// RULE5 - Indexed data reference adds index register to displacement.
// RULE6 - Direct code reference is PC plus displacement, read only.
// RULE7 - Indexed code reference adds index register to PC plus displacement.
// RULE8 - Code space is never written.
// RULE9 - Index and displacement are signed two's complement in the addition.
// RULE10 - Effective address is an unsigned 32-bit offset from zero.
// RULE11 - All formats take the same time; no extra cycles for indexing.
// RULE12 - PC plus displacement is precomputed at prefetch, index added later.
// RULE13 - Processor accesses are virtual and translated; DMA uses real addresses.
// RULE14 - Memory corrects single-bit and detects double-bit errors.
// RULE15 - Four bytes per 375 ns memory cycle; one to eight megabytes.
// RULE16 - I/O side uses a multiplexed 500 ns cycle; boards bring own DMA.
// RULE17 - Byte addressing; sizes 8/16/32/64 bits, most significant byte first.
// RULE18 - Doubleword uses register x and (x+1) mod 16, high half in x.
// RULE19 - Single real: sign, 8-bit exponent bias 127, 23-bit mantissa.
// RULE20 - Double real: sign, 11-bit exponent bias 1023, 52-bit mantissa.
// RULE21 - Bit 7 indexed, bits 8-11 destination, 12-15 index, 16 up displacement.
// RULE22 - Data must be aligned to a multiple of its own length.
`ifndef MRAG_DEFS_SVH
`define MRAG_DEFS_SVH
`define MRAG_ADDR_REG_CTRL 32'h0000_0000
`define MRAG_ADDR_REG_INSN_HI 32'h0000_0004
`define MRAG_ADDR_REG_INSN_LO 32'h0000_0008
`define MRAG_ADDR_REG_PC 32'h0000_000C
`define MRAG_ADDR_REG_INDEX 32'h0000_0010
`define MRAG_ADDR_REG_EA 32'h0000_0014
`define MRAG_ADDR_REG_STATUS 32'h0000_0018
`define MRAG_ADDR_REG_DPAIR 32'h0000_001C
`define MRAG_ADDR_REG_FPINFO 32'h0000_0020
`define MRAG_ADDR_REG_TIMING 32'h0000_0024
`define MRAG_CTRL_GO_BIT 0
`define MRAG_CTRL_STORE_BIT 1
`define MRAG_CTRL_SIZE_LSB 2
`define MRAG_CTRL_DMA_BIT 4
`define MRAG_CTRL_FPDBL_BIT 5
`define MRAG_BIT_SPACE_HI 1
`define MRAG_BIT_SPACE_LO 2
`define MRAG_BIT_LONG 3
`define MRAG_BIT_INDEXED 7
`define MRAG_SP_EXP_BIAS 127
`define MRAG_DP_EXP_BIAS 1023
`define MRAG_MEM_CYCLE_NS 375
`define MRAG_IO_CYCLE_NS 500
`define MRAG_CLK_NS 5
`define MRAG_MEM_CYCLES ((`MRAG_MEM_CYCLE_NS + `MRAG_CLK_NS - 1) / `MRAG_CLK_NS)
`define MRAG_IO_CYCLES ((`MRAG_IO_CYCLE_NS + `MRAG_CLK_NS - 1) / `MRAG_CLK_NS)
`define MRAG_MIN_MBYTES 1
`define MRAG_MAX_MBYTES 8
`endif

// >>> core/mrag_pkg.sv
// Types for the memory reference address generator.
package mrag_pkg;
   typedef enum logic [1:0] {MRAG_SZ_BYTE, MRAG_SZ_HALF, MRAG_SZ_WORD, MRAG_SZ_DBL} mrag_size_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [3:0] dest_reg;
      logic [3:0] index_register_field;
      logic [31:0] disp;
   } mrag_insn_t;
   typedef struct packed {
      logic indexed;
      logic long_disp;
      logic code_space;
      logic [3:0] target_register_pair;
      logic [3:0] pair_low_reg;
   } mrag_decode_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic real_addr;
      logic [31:0] addr;
   } mrag_mem_req_t;
endpackage

// >>> core/mrag_top.sv
// Memory reference decoder and effective address generator with AHB-Lite registers.
`include "mrag_defs.svh"
module mrag_top
   import mrag_pkg::*;
#(
   parameter int MEM_CYCLES = `MRAG_MEM_CYCLES,
   parameter int IO_CYCLES = `MRAG_IO_CYCLES
) (
   // Clock, reset and enable.
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Memory request toward the controller.
   output logic mem_valid,
   output logic mem_write,
   output logic mem_real,
   output logic [31:0] mem_addr,
   output logic [1:0] mem_size
);

   logic [31:0] ctrl_q;
   logic [31:0] insn_hi_q;
   logic [15:0] insn_lo_q;
   logic [31:0] pc_q;
   logic [31:0] index_q;
   logic [31:0] pcdisp_q;
   logic [31:0] ea_q;
   logic busy_q;
   logic code_wr_err_q;
   logic align_err_q;
   logic done_q;
   mrag_mem_req_t req_q;
   logic [1:0] size_q;
   logic ap_wr_q;
   logic ap_rd_q;
   logic [31:0] ap_addr_q;
   logic [31:0] rdata_d;

   mrag_insn_t insn;
   mrag_decode_t dec;
   logic [31:0] disp_ext;
   logic [31:0] ea_d;
   logic misaligned;
   logic ap_take;
   logic go_wr;

   // The instruction is held as one 48-bit image: high word plus low halfword.
   always_comb begin
      insn.opcode = insn_hi_q[31:24];
      insn.dest_reg = insn_hi_q[23:20]; // [RULE21]
      insn.index_register_field = insn_hi_q[19:16]; // [RULE21]
      insn.disp = {insn_hi_q[15:0], insn_lo_q};
   end

   always_comb begin
      dec.indexed = insn.opcode[7 - `MRAG_BIT_INDEXED]; // [RULE3] [RULE21]
      dec.long_disp = insn.opcode[7 - `MRAG_BIT_LONG]; // [RULE3]
      // Equal space bits select code space. [RULE3]
      dec.code_space = ~(insn.opcode[7 - `MRAG_BIT_SPACE_HI] ^ insn.opcode[7 - `MRAG_BIT_SPACE_LO]);
      dec.target_register_pair = insn.dest_reg; // [RULE18]
      dec.pair_low_reg = 4'(insn.dest_reg + 4'h1); // [RULE18]
   end

   // Short form: upper halfword of the displacement field is the displacement. [RULE1] [RULE2]
   assign disp_ext = dec.long_disp ? insn.disp : {{16{insn.disp[31]}}, insn.disp[31:16]};

   // Signed addition wraps modulo 2**32, which reads as an unsigned offset. [RULE9] [RULE10]
   always_comb begin
      if (dec.code_space) begin
         ea_d = dec.indexed ? 32'(pcdisp_q + index_q) : pcdisp_q; // [RULE6] [RULE7] [RULE12]
      end else begin
         ea_d = dec.indexed ? 32'(disp_ext + index_q) : disp_ext; // [RULE4] [RULE5]
      end
   end

   // Alignment to the operand's own length. [RULE22] [RULE17]
   always_comb begin
      unique case (mrag_size_t'(ctrl_q[`MRAG_CTRL_SIZE_LSB +: 2]))
         MRAG_SZ_BYTE: misaligned = 1'b0;
         MRAG_SZ_HALF: misaligned = ea_d[0];
         MRAG_SZ_WORD: misaligned = |ea_d[1:0];
         MRAG_SZ_DBL: misaligned = |ea_d[2:0];
      endcase
   end

   // AHB-Lite address phase capture; the slave is always ready with OKAY.
   assign ap_take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q <= 1'b0;
         ap_rd_q <= 1'b0;
         ap_addr_q <= 32'h0000_0000;
      end else if (clk_en) begin
         ap_wr_q <= ap_take & hwrite;
         ap_rd_q <= ap_take & ~hwrite;
         if (ap_take) begin
            ap_addr_q <= haddr;
         end
      end
   end

   assign go_wr = ap_wr_q && ap_addr_q == `MRAG_ADDR_REG_CTRL && hwdata[`MRAG_CTRL_GO_BIT];

   // Software-written registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= 32'h0000_0000;
         insn_hi_q <= 32'h0000_0000;
         insn_lo_q <= 16'h0000;
         pc_q <= 32'h0000_0000;
         index_q <= 32'h0000_0000;
      end else if (clk_en && ap_wr_q) begin
         unique case (ap_addr_q)
            `MRAG_ADDR_REG_CTRL: ctrl_q <= {26'h0, hwdata[5:1], 1'b0};
            `MRAG_ADDR_REG_INSN_HI: insn_hi_q <= hwdata;
            `MRAG_ADDR_REG_INSN_LO: insn_lo_q <= hwdata[15:0];
            `MRAG_ADDR_REG_PC: pc_q <= hwdata;
            `MRAG_ADDR_REG_INDEX: index_q <= hwdata;
            default: ;
         endcase
      end
   end

   // Prefetch precompute of PC plus displacement, kept current with PC and image. [RULE12]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcdisp_q <= 32'h0000_0000;
      end else if (clk_en) begin
         pcdisp_q <= 32'(pc_q + disp_ext);
      end
   end

   // Launch: the same single cycle for every format, index add included. [RULE11]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= '0;
         size_q <= 2'b00;
         ea_q <= 32'h0000_0000;
         done_q <= 1'b0;
      end else if (clk_en) begin
         req_q.valid <= 1'b0;
         if (go_wr && !busy_q) begin
            ea_q <= ea_d;
            done_q <= 1'b1;
            size_q <= ctrl_q[`MRAG_CTRL_SIZE_LSB +: 2];
            // Misaligned or code-space stores are never issued. [RULE8] [RULE22]
            req_q.valid <= ~misaligned & ~(dec.code_space & ctrl_q[`MRAG_CTRL_STORE_BIT]);
            req_q.write <= ctrl_q[`MRAG_CTRL_STORE_BIT] & ~dec.code_space; // [RULE8]
            req_q.real_addr <= ctrl_q[`MRAG_CTRL_DMA_BIT]; // [RULE13]
            req_q.addr <= ea_d;
         end
      end
   end

   // Error flags: set wins over a clear written in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_wr_err_q <= 1'b0;
         align_err_q <= 1'b0;
      end else if (clk_en) begin
         if (go_wr && !busy_q && dec.code_space && ctrl_q[`MRAG_CTRL_STORE_BIT]) begin
            code_wr_err_q <= 1'b1; // [RULE8]
         end else if (ap_wr_q && ap_addr_q == `MRAG_ADDR_REG_STATUS && hwdata[1]) begin
            code_wr_err_q <= 1'b0;
         end
         if (go_wr && !busy_q && misaligned) begin
            align_err_q <= 1'b1; // [RULE22]
         end else if (ap_wr_q && ap_addr_q == `MRAG_ADDR_REG_STATUS && hwdata[2]) begin
            align_err_q <= 1'b0;
         end
      end
   end

   // Memory cycle pacing: processor 375 ns, DMA side 500 ns. [RULE15] [RULE16]
   // Error correction stays in the controller; it only needs one request per cycle. [RULE14]
   logic [7:0] cyc_cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_cnt_q <= 8'h00;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         if (req_q.valid) begin
            busy_q <= 1'b1;
            cyc_cnt_q <= req_q.real_addr ? 8'(IO_CYCLES - 1) : 8'(MEM_CYCLES - 1);
         end else if (busy_q) begin
            if (cyc_cnt_q == 8'h00) begin
               busy_q <= 1'b0;
            end else begin
               cyc_cnt_q <= 8'(cyc_cnt_q - 8'h01);
            end
         end
      end
   end

   assign mem_valid = req_q.valid;
   assign mem_write = req_q.write;
   assign mem_real = req_q.real_addr;
   assign mem_addr = req_q.addr;
   assign mem_size = size_q;

   // Read mux; unmapped addresses read zero.
   always_comb begin
      unique case (ap_addr_q)
         `MRAG_ADDR_REG_CTRL: rdata_d = ctrl_q;
         `MRAG_ADDR_REG_INSN_HI: rdata_d = insn_hi_q;
         `MRAG_ADDR_REG_INSN_LO: rdata_d = {16'h0000, insn_lo_q};
         `MRAG_ADDR_REG_PC: rdata_d = pc_q;
         `MRAG_ADDR_REG_INDEX: rdata_d = index_q;
         `MRAG_ADDR_REG_EA: rdata_d = ea_q;
         `MRAG_ADDR_REG_STATUS: rdata_d = {25'h0, dec.code_space, dec.long_disp, dec.indexed,
                                           align_err_q, code_wr_err_q, done_q | busy_q};
         `MRAG_ADDR_REG_DPAIR: rdata_d = {24'h0, dec.pair_low_reg, dec.target_register_pair};
         // Exponent biases of the single and double real formats. [RULE19] [RULE20]
         `MRAG_ADDR_REG_FPINFO: rdata_d = {5'h00, 11'(`MRAG_DP_EXP_BIAS), 8'h00, 8'(`MRAG_SP_EXP_BIAS)};
         `MRAG_ADDR_REG_TIMING: rdata_d = {16'(IO_CYCLES), 16'(MEM_CYCLES)};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   assign hrdata = rdata_d;

   // Checks.
   AST_SIGNEXT: assert property (@(posedge hclk) disable iff (!hresetn)
      !dec.long_disp |-> disp_ext[31:16] == {16{insn_hi_q[15]}}) else $error("short disp not sign extended"); // [RULE1]
   AST_LONGDISP: assert property (@(posedge hclk) disable iff (!hresetn)
      dec.long_disp |-> disp_ext == {insn_hi_q[15:0], insn_lo_q}) else $error("long disp altered"); // [RULE2]
   AST_DATA_DIRECT: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && go_wr && !busy_q && !dec.code_space && !dec.indexed |=> ea_q == $past(disp_ext))
      else $error("direct data address wrong"); // [RULE4]
   AST_DATA_INDEX: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && go_wr && !busy_q && !dec.code_space && dec.indexed |=> ea_q == 32'($past(disp_ext) + $past(index_q)))
      else $error("indexed data address wrong"); // [RULE5]
   AST_CODE_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && go_wr && !busy_q && dec.code_space |=>
      ea_q == 32'($past(pcdisp_q) + ($past(dec.indexed) ? $past(index_q) : 32'h0)))
      else $error("code address wrong"); // [RULE6]
   AST_NO_CODE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && go_wr && !busy_q && dec.code_space |=> !mem_write) else $error("code space written"); // [RULE8]
   AST_ONE_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && go_wr && !busy_q && !misaligned && !(dec.code_space && ctrl_q[1]) |=> mem_valid)
      else $error("launch not in one cycle"); // [RULE11]
   AST_ALIGN: assert property (@(posedge hclk) disable iff (!hresetn)
      mem_valid && mem_size == 2'b11 |-> mem_addr[2:0] == 3'b000) else $error("misaligned double"); // [RULE22]
   AST_PAIR: assert property (@(posedge hclk) disable iff (!hresetn)
      dec.pair_low_reg == 4'(dec.target_register_pair + 4'h1)) else $error("pair wrap wrong"); // [RULE18]

   // A launch that really happens; many of the checks below key on it.
   logic launch_chk;
   assign launch_chk = clk_en && go_wr && !busy_q;

   // Decode of the instruction image.
   AST_SPACE_DECODE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
      dec.code_space == (insn_hi_q[30] == insn_hi_q[29]))
      else $error("space decode wrong");

   AST_INDEX_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3] [RULE21]
      dec.indexed == insn_hi_q[24])
      else $error("indexed flag wrong");

   AST_LONG_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
      dec.long_disp == insn_hi_q[28])
      else $error("long flag wrong");

   AST_FIELDS: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE21]
      insn.index_register_field == insn_hi_q[19:16] && insn.dest_reg == insn_hi_q[23:20])
      else $error("register fields wrong");

   AST_PAIR_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
      dec.target_register_pair == insn_hi_q[23:20])
      else $error("pair high register wrong");

   // Address arithmetic.
   AST_CODE_INDEX: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
      launch_chk && dec.code_space && dec.indexed |=> ea_q == 32'($past(pcdisp_q) + $past(index_q)))
      else $error("indexed code address wrong");

   AST_PCDISP: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
      clk_en |=> pcdisp_q == 32'($past(pc_q) + $past(disp_ext)))
      else $error("precomputed sum wrong");

   AST_EA_TO_MEM: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
      mem_valid |-> mem_addr == ea_q)
      else $error("request address differs from effective address");

   AST_EA_HELD: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      clk_en && !launch_chk |=> $stable(ea_q))
      else $error("effective address moved without launch");

   // Request issue and its flags.
   AST_LOAD_DATA: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
      launch_chk && !dec.code_space && !ctrl_q[`MRAG_CTRL_STORE_BIT] && !misaligned |=> mem_valid && !mem_write)
      else $error("data load not issued");

   AST_WRITE_DATA: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
      launch_chk && !dec.code_space && ctrl_q[`MRAG_CTRL_STORE_BIT] && !misaligned |=> mem_valid && mem_write)
      else $error("data store not issued");

   AST_CODE_READ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
      launch_chk && dec.code_space && !ctrl_q[`MRAG_CTRL_STORE_BIT] && !misaligned |=> mem_valid && !mem_write)
      else $error("code read not issued");

   AST_CODE_ERR: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
      launch_chk && dec.code_space && ctrl_q[`MRAG_CTRL_STORE_BIT] |=> code_wr_err_q && !mem_valid)
      else $error("code store not refused");

   AST_STATUS_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
      clk_en && !launch_chk && ap_wr_q && ap_addr_q == `MRAG_ADDR_REG_STATUS && hwdata[1] |=> !code_wr_err_q)
      else $error("code error flag not cleared");

   AST_ALIGN_ERR: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22]
      launch_chk && misaligned |=> align_err_q && !mem_valid)
      else $error("misaligned access not refused");

   AST_HALF_ALIGN: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22] [RULE17]
      mem_valid && mem_size == 2'b01 |-> !mem_addr[0])
      else $error("misaligned halfword");

   AST_WORD_ALIGN: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22] [RULE17]
      mem_valid && mem_size == 2'b10 |-> mem_addr[1:0] == 2'b00)
      else $error("misaligned word");

   AST_SIZE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
      launch_chk |=> mem_size == $past(ctrl_q[`MRAG_CTRL_SIZE_LSB +: 2]))
      else $error("operand size not passed on");

   AST_REAL: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13]
      launch_chk |=> mem_real == $past(ctrl_q[`MRAG_CTRL_DMA_BIT]))
      else $error("real address flag wrong");

   AST_DONE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      launch_chk |=> done_q)
      else $error("done not set");

   AST_VALID_PULSE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      clk_en && mem_valid |=> !mem_valid)
      else $error("request longer than one cycle");

   AST_IDLE_NO_REQ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      clk_en && !launch_chk |=> !mem_valid)
      else $error("request without launch");

   // Memory cycle pacing.
   AST_BUSY_AFTER_REQ: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
      clk_en && mem_valid |=> busy_q)
      else $error("busy not set after request");

   AST_NO_GO_WHILE_BUSY: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
      clk_en && busy_q |=> !mem_valid)
      else $error("request issued while busy");

   AST_CPU_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
      clk_en && mem_valid && !mem_real |=> cyc_cnt_q == 8'(MEM_CYCLES - 1))
      else $error("memory cycle count wrong");

   AST_IO_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
      clk_en && mem_valid && mem_real |=> cyc_cnt_q == 8'(IO_CYCLES - 1))
      else $error("I/O cycle count wrong");

   // Bus and clock enable.
   AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus response not ready with OKAY");

   AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
      !clk_en |=> $stable(ea_q) && $stable(ctrl_q) && $stable(busy_q) && $stable(cyc_cnt_q))
      else $error("state moved while clock enable low");

endmodule // mrag_top

// >>> dv/mrag_mem_model.sv
// Behavioural memory controller that accepts and records address requests.
module mrag_mem_model
   import mrag_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Request from the address generator.
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic mem_real,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] mem_size,
   // Observation for the bench.
   output mrag_mem_req_t last_req,
   output logic [1:0] last_size,
   output int req_count,
   output int cyc_now,
   output int req_cyc
);
   // Translation and error correction are not modelled; only the real flag says whether translation applies.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_now <= 0;
         req_count <= 0;
         req_cyc <= 0;
         last_req <= '0;
         last_size <= 2'h0;
      end else begin
         cyc_now <= cyc_now + 1;
         if (mem_valid) begin
            last_req <= '{valid: 1'b1, write: mem_write, real_addr: mem_real, addr: mem_addr};
            last_size <= mem_size;
            req_count <= req_count + 1;
            req_cyc <= cyc_now;
         end
      end
   end
endmodule // mrag_mem_model

// >>> dv/tb_memory_reference_address_gen.sv
// Self-checking bench for the memory reference address generator.
`include "mrag_defs.svh"
module tb_memory_reference_address_gen;
   import mrag_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
   logic mem_valid, mem_write, mem_real;
   logic [31:0] haddr, hwdata, hrdata, mem_addr, rd;
   logic [1:0] htrans, mem_size, last_size;
   logic [2:0] hsize;
   mrag_mem_req_t last_req;
   int req_count, cyc_now, req_cyc, fail_count, n_tests, cyc;
   mrag_top #(.MEM_CYCLES(6), .IO_CYCLES(8)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_valid(mem_valid), .mem_write(mem_write),
      .mem_real(mem_real), .mem_addr(mem_addr), .mem_size(mem_size));
   mrag_mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_valid(mem_valid), .mem_write(mem_write),
      .mem_real(mem_real), .mem_addr(mem_addr), .mem_size(mem_size), .last_req(last_req), .last_size(last_size),
      .req_count(req_count), .cyc_now(cyc_now), .req_cyc(req_cyc));
   always #2.5 hclk = ~hclk;
   task automatic conclude();
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Generous ceiling: each case needs about 30 cycles.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Runs one memory reference and compares the request with the effective address worked out here.
   task automatic run(input logic [1:0] sp, input logic lng, input logic idx, input logic [15:0] hi,
      input logic [15:0] lo, input logic [31:0] pc, input logic [31:0] ix, input logic st, input logic [1:0] sz,
      input logic dma);
      logic code, bad, mis;
      logic [31:0] disp, ea, ctrl;
      int n0, go;
      code = (sp == 2'h0) || (sp == 2'h3);
      disp = lng ? {hi, lo} : {{16{hi[15]}}, hi};
      ea = (code ? pc : 32'h0) + (idx ? ix : 32'h0) + disp;
      mis = ((ea & ((32'h1 << sz) - 32'h1)) != 32'h0);
      bad = code && st;
      ctrl = {27'h0, dma, sz, st, 1'b0};
      ahb(1'b1, `MRAG_ADDR_REG_INSN_HI, {1'b0, sp, lng, 3'h0, idx, 4'hF, 4'h3, hi});
      ahb(1'b1, `MRAG_ADDR_REG_INSN_LO, {16'h0, lo});
      ahb(1'b1, `MRAG_ADDR_REG_PC, pc);
      ahb(1'b1, `MRAG_ADDR_REG_INDEX, ix);
      ahb(1'b1, `MRAG_ADDR_REG_CTRL, ctrl);
      n0 = req_count;
      go = cyc_now;
      ahb(1'b1, `MRAG_ADDR_REG_CTRL, ctrl | 32'h1);
      repeat (12) @(posedge hclk);
      chk("request count", req_count - n0, (bad || mis) ? 0 : 1);
      ahb(1'b0, `MRAG_ADDR_REG_STATUS, 32'h0);
      chk("status flags", rd & 32'h3E, {26'h0, code, lng, idx, mis, bad, 1'b0});
      if (!(bad || mis)) begin
         // Address phase, data phase, then the request is seen one edge later.
         chk("latency", req_cyc - go, 32'd3);
         chk("address", last_req.addr, ea);
         chk("write", last_req.write, st);
         chk("real", last_req.real_addr, dma);
         chk("size", last_size, sz);
         ahb(1'b0, `MRAG_ADDR_REG_EA, 32'h0);
         chk("ea register", rd, ea);
      end
      ahb(1'b1, `MRAG_ADDR_REG_STATUS, 32'h6);
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      run(2'h1, 1'b0, 1'b0, 16'h8000, 16'h0, 32'h0, 32'h0, 1'b0, 2'h0, 1'b0);
      run(2'h2, 1'b0, 1'b1, 16'h0010, 16'h0, 32'h0, 32'hFFFF_FFF0, 1'b1, 2'h2, 1'b0);
      run(2'h0, 1'b0, 1'b0, 16'hFFFC, 16'h0, 32'h0000_1000, 32'h0, 1'b0, 2'h2, 1'b0);
      run(2'h3, 1'b1, 1'b1, 16'h1234, 16'h5678, 32'h0000_0100, 32'h8, 1'b0, 2'h3, 1'b0);
      run(2'h1, 1'b1, 1'b0, 16'h8000, 16'h0002, 32'h0, 32'h0, 1'b1, 2'h1, 1'b1);
      run(2'h0, 1'b0, 1'b0, 16'h0008, 16'h0, 32'h0000_0020, 32'h0, 1'b1, 2'h2, 1'b0);
      run(2'h1, 1'b0, 1'b0, 16'h0006, 16'h0, 32'h0, 32'h0, 1'b1, 2'h2, 1'b0);
      ahb(1'b0, `MRAG_ADDR_REG_DPAIR, 32'h0);
      chk("register pair", rd, 32'h0000_000F);
      ahb(1'b0, `MRAG_ADDR_REG_FPINFO, 32'h0);
      chk("float biases", rd, 32'h03FF_007F);
      ahb(1'b0, `MRAG_ADDR_REG_TIMING, 32'h0);
      chk("cycle counts", rd, 32'h0008_0006);
      // A write made while the clock enable is low must not land.
      clk_en <= 1'b0;
      ahb(1'b1, `MRAG_ADDR_REG_PC, 32'hDEAD_BEEF);
      clk_en <= 1'b1;
      ahb(1'b0, `MRAG_ADDR_REG_PC, 32'h0);
      chk("frozen write", rd, 32'h0);
      ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h0000_0040, 32'h0);
      chk("unmapped read", rd, 32'h0);
      chk("response", hresp, 1'b0);
      conclude();
   end
endmodule // tb_memory_reference_address_gen
